// ### verilog/eqpt_regs.svh
// register offsets, field positions and reset values of the equalizer/phase-tracker bank
`ifndef EQPT_REGS_SVH
`define EQPT_REGS_SVH
`define EQPT_OFF_FBCTRL 8'h23
`define EQPT_OFF_PTCTRL 8'h24
`define EQPT_OFF_TAP 8'h25
`define EQPT_OFF_COEFHI 8'h26
`define EQPT_OFF_WRLO 8'h27
`define EQPT_OFF_RDLO 8'h28
`define EQPT_OFF_RNGHI 8'h29
`define EQPT_OFF_RNGLO 8'h2a
`define EQPT_OFF_EQIMID 8'h2b
`define EQPT_OFF_EQILO 8'h2c
`define EQPT_OFF_EQOMID 8'h2d
`define EQPT_OFF_EQOLO 8'h2e
`define EQPT_OFF_CLIPHI 8'h2f
`define EQPT_OFF_PTOMID 8'h30
`define EQPT_OFF_PTOLO 8'h31
`define EQPT_OFF_UPLO 8'h32
`define EQPT_OFF_LOLO 8'h33
`define EQPT_OFF_DCLO 8'h34
`define EQPT_RST_FBCTRL 8'ha7
`define EQPT_RST_PTCTRL 8'hc3
`define EQPT_RST_TAP 8'h00
`define EQPT_RST_WRHI 4'h0
`define EQPT_RST_WRLO 8'h00
`define EQPT_RST_RNGHI 2'h0
`define EQPT_RST_RNGLO 8'h90
`define EQPT_RST_UPHI 2'h1
`define EQPT_RST_LOHI 2'h3
`define EQPT_RST_CLIPLO 8'h00
`define EQPT_BIT_FB16OFF 7
`define EQPT_BIT_FBSEL 6
`define EQPT_BIT_ADAPT 5
`define EQPT_BIT_LOCK 2
`define EQPT_BIT_DIR 1
`define EQPT_BIT_MODEN 0
`define EQPT_FF_TAPS 8'h40
`endif

// ### verilog/eqpt_pkg.sv
// types shared by the equalizer/phase-tracker register bank
package eqpt_pkg;
    typedef enum logic [1:0] {EQPT_BLIND_OFF, EQPT_BLIND_4LVL, EQPT_BLIND_2LVL} eqpt_blind_e;
    typedef enum logic [2:0] {EQPT_GAIN_AUTO, EQPT_GAIN_OFF, EQPT_GAIN_SMALL, EQPT_GAIN_NORMAL,
                              EQPT_GAIN_UNUSED} eqpt_gain_e;
    typedef logic [11:0] eqpt_coef_t;
    typedef logic [18:0] eqpt_mse_t;
endpackage

// ### verilog/eqpt_ctrl_regs.sv
// register bank that configures and monitors the equalizer and phase tracker
// Operation
// - bit 7 of 0x23 at 0 turns feedback filter on in 16-level mode; reset 1
// - bit 6 at 0 runs feedback filter in 2/4/8 level, 1 only 8-level
// - bit 5 at 1 adapts in training only, else also in data; reset 1
// - bits 4:3 pick blind mode: off, 4-level, or 2-level decisions
// - while lock bit is 1, access-mode bit cannot be changed; reset 1
// - direction bit: 0 reads coefficient, 1 writes coefficient; reset 1
// - access-mode bit 0 opens coefficient access, 1 is normal operation
// - slice prediction field: 00 off, 11 on, others unused; reset 11
// - loop gain field: auto, tracker off, smaller, normal; 1xx unused
// - range bit: 0 gives plus-minus 60 degrees, 1 plus-minus 45
// - gain value and automatic threshold select bits, both reset 1
// - tap index 0..63 feed-forward, 64..255 feedback taps; reset zero
// - write coefficient is 12 bits: high nibble bits 7:4, low byte next
// - read coefficient: high nibble in bits 3:0, low byte separate register
// - 10-bit data adaptation range, reset high 00 and low 0x90
// - 19-bit input MSE: top bits in 5:3, rest in two registers
// - 19-bit output MSE: bits 17:16 in 2:1, bits 15:0 in two registers, bit 18 not readable
// - 19-bit tracker MSE: top bits in 7:5, rest in two registers
// - positive upper clip limit; errors above it forced to zero
// - negative lower clip limit; errors below it forced to zero
// - 9-bit DC offset readback: bit 8 in bit 0, low byte separate
`include "eqpt_regs.svh"

module eqpt_ctrl_regs #(
    parameter int ERR_W = 10 // equalizer error width
) (
    input wire logic mclk, // system clock
    input wire logic sys_rst, // synchronous reset, active high
    input wire logic regWr, // one-cycle register write strobe
    input wire logic regRd, // one-cycle register read strobe
    input wire logic [7:0] regAddr, // register address
    input wire logic [7:0] regWdata, // write data
    output logic [7:0] regRdata, // read data, registered
    output logic regAck, // read data valid, one cycle
    input wire logic [1:0] vsbLevel, // active mode 0:2 1:4 2:8 3:16 level
    input wire logic trainingActive, // training sequence interval
    input wire logic [11:0] coefReadValue, // coefficient from equalizer
    input wire logic [18:0] eqInMse, // equalizer input mse
    input wire logic [18:0] eqOutMse, // equalizer output mse
    input wire logic [18:0] ptOutMse, // phase tracker output mse
    input wire logic [8:0] dcLevelReadback, // dc reduction offset
    input wire logic signed [ERR_W-1:0] eqErrIn, // raw equalizer error
    output logic signed [ERR_W-1:0] eqErrOut, // clipped equalizer error, registered
    output logic fbFilterOn, // feedback filter enable
    output logic adaptEnable, // coefficient adaptation enable
    output eqpt_pkg::eqpt_blind_e blindMode, // blind equalization mode
    output logic coefAccessOpen, // coefficient access mode
    output logic coefWriteStrobe, // write coefficient to tap, one cycle
    output logic coefReadStrobe, // capture coefficient from tap, one cycle
    output logic [7:0] tapIndex, // selected tap
    output logic tapIsFeedback, // tap belongs to feedback filter
    output eqpt_pkg::eqpt_coef_t coefWriteValue, // coefficient to write
    output logic [9:0] dataAdaptRange, // data adaptation range
    output logic slicePredOn, // slice prediction enable
    output eqpt_pkg::eqpt_gain_e loopGainMode, // loop gain selection
    output logic phaseRange45, // 1: plus-minus 45 deg range
    output logic loopGainValueSel, // loop gain value choice
    output logic loopGainThreshSel // automatic gain threshold choice
);

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    if (ERR_W != 10) begin : g_errWidthCheck
        $error("eqpt_ctrl_regs: clip limits are 10 bits, ERR_W must be 10");
    end

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    logic [7:0] fbCtrl_reg;
    logic [7:0] ptCtrl_reg;
    logic [7:0] tap_reg;
    logic [3:0] wrHi_reg;
    logic [7:0] wrLo_reg;
    logic [1:0] rngHi_reg;
    logic [7:0] rngLo_reg;
    logic [1:0] upHi_reg;
    logic [1:0] loHi_reg;
    logic [7:0] upLo_reg;
    logic [7:0] loLo_reg;
    logic [7:0] fbCtrl_next;
    logic wrSel;

    assign wrSel = regWr;

    always_comb begin
        fbCtrl_next = regWdata;
        if (fbCtrl_reg[`EQPT_BIT_LOCK]) begin
            fbCtrl_next[`EQPT_BIT_MODEN] = fbCtrl_reg[`EQPT_BIT_MODEN];
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            fbCtrl_reg <= `EQPT_RST_FBCTRL;
        end else if (wrSel && regAddr == `EQPT_OFF_FBCTRL) begin
            fbCtrl_reg <= fbCtrl_next;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ptCtrl_reg <= `EQPT_RST_PTCTRL;
        end else if (wrSel && regAddr == `EQPT_OFF_PTCTRL) begin
            ptCtrl_reg <= regWdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            tap_reg <= `EQPT_RST_TAP;
        end else if (wrSel && regAddr == `EQPT_OFF_TAP) begin
            tap_reg <= regWdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wrHi_reg <= `EQPT_RST_WRHI;
            wrLo_reg <= `EQPT_RST_WRLO;
        end else begin
            if (wrSel && regAddr == `EQPT_OFF_COEFHI) begin
                wrHi_reg <= regWdata[7:4];
            end
            if (wrSel && regAddr == `EQPT_OFF_WRLO) begin
                wrLo_reg <= regWdata;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rngHi_reg <= `EQPT_RST_RNGHI;
            rngLo_reg <= `EQPT_RST_RNGLO;
        end else begin
            if (wrSel && regAddr == `EQPT_OFF_RNGHI) begin
                rngHi_reg <= regWdata[7:6];
            end
            if (wrSel && regAddr == `EQPT_OFF_RNGLO) begin
                rngLo_reg <= regWdata;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            upHi_reg <= `EQPT_RST_UPHI;
            loHi_reg <= `EQPT_RST_LOHI;
            upLo_reg <= `EQPT_RST_CLIPLO;
            loLo_reg <= `EQPT_RST_CLIPLO;
        end else begin
            if (wrSel && regAddr == `EQPT_OFF_CLIPHI) begin
                upHi_reg <= regWdata[4:3];
                loHi_reg <= regWdata[2:1];
            end
            if (wrSel && regAddr == `EQPT_OFF_UPLO) begin
                upLo_reg <= regWdata;
            end
            if (wrSel && regAddr == `EQPT_OFF_LOLO) begin
                loLo_reg <= regWdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // decoded controls
    // ----------------------------------------------------------------
    // feedback filter enable
    always_comb begin
        fbFilterOn = 1'b0;
        unique case (vsbLevel)
            2'h3: fbFilterOn = !fbCtrl_reg[`EQPT_BIT_FB16OFF];
            2'h2: fbFilterOn = 1'b1;
            2'h1, 2'h0: fbFilterOn = !fbCtrl_reg[`EQPT_BIT_FBSEL];
        endcase
    end

    assign adaptEnable = trainingActive || !fbCtrl_reg[`EQPT_BIT_ADAPT];

    always_comb begin
        unique case (fbCtrl_reg[4:3])
            2'h0: blindMode = eqpt_pkg::EQPT_BLIND_OFF;
            2'h1: blindMode = eqpt_pkg::EQPT_BLIND_4LVL;
            2'h2, 2'h3: blindMode = eqpt_pkg::EQPT_BLIND_2LVL;
        endcase
    end

    assign coefAccessOpen = !fbCtrl_reg[`EQPT_BIT_MODEN];

    // transfer strobes: write fired by writing the low coefficient byte, read fired by writing the tap index
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            coefWriteStrobe <= 1'b0;
            coefReadStrobe <= 1'b0;
        end else begin
            coefWriteStrobe <= wrSel && regAddr == `EQPT_OFF_WRLO && coefAccessOpen && fbCtrl_reg[`EQPT_BIT_DIR];
            coefReadStrobe <= wrSel && regAddr == `EQPT_OFF_TAP && coefAccessOpen && !fbCtrl_reg[`EQPT_BIT_DIR];
        end
    end

    assign tapIndex = tap_reg;
    assign tapIsFeedback = tap_reg >= `EQPT_FF_TAPS;
    assign coefWriteValue = {wrHi_reg, wrLo_reg};
    assign dataAdaptRange = {rngHi_reg, rngLo_reg};
    assign slicePredOn = ptCtrl_reg[7:6] == 2'h3;
    assign phaseRange45 = ptCtrl_reg[2];
    assign loopGainValueSel = ptCtrl_reg[1];
    assign loopGainThreshSel = ptCtrl_reg[0];

    always_comb begin
        unique case (ptCtrl_reg[5:3])
            3'h0: loopGainMode = eqpt_pkg::EQPT_GAIN_AUTO;
            3'h1: loopGainMode = eqpt_pkg::EQPT_GAIN_OFF;
            3'h2: loopGainMode = eqpt_pkg::EQPT_GAIN_SMALL;
            3'h3: loopGainMode = eqpt_pkg::EQPT_GAIN_NORMAL;
            default: loopGainMode = eqpt_pkg::EQPT_GAIN_UNUSED;
        endcase
    end

    // ----------------------------------------------------------------
    // error clipping
    // ----------------------------------------------------------------
    logic signed [ERR_W-1:0] upLimit;
    logic signed [ERR_W-1:0] loLimit;
    assign upLimit = {upHi_reg, upLo_reg};
    assign loLimit = {loHi_reg, loLo_reg};

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            eqErrOut <= '0;
        end else if (eqErrIn > upLimit || eqErrIn < loLimit) begin
            eqErrOut <= '0;
        end else begin
            eqErrOut <= eqErrIn;
        end
    end

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    logic [7:0] rdMux;
    always_comb begin
        rdMux = 8'h00;
        unique case (regAddr)
            `EQPT_OFF_FBCTRL: rdMux = fbCtrl_reg;
            `EQPT_OFF_PTCTRL: rdMux = ptCtrl_reg;
            `EQPT_OFF_TAP: rdMux = tap_reg;
            `EQPT_OFF_COEFHI: rdMux = {wrHi_reg, coefReadValue[11:8]};
            `EQPT_OFF_WRLO: rdMux = wrLo_reg;
            `EQPT_OFF_RDLO: rdMux = coefReadValue[7:0];
            `EQPT_OFF_RNGHI: rdMux = {rngHi_reg, eqInMse[18:16], eqOutMse[17:16], 1'b0};
            `EQPT_OFF_RNGLO: rdMux = rngLo_reg;
            `EQPT_OFF_EQIMID: rdMux = eqInMse[15:8];
            `EQPT_OFF_EQILO: rdMux = eqInMse[7:0];
            `EQPT_OFF_EQOMID: rdMux = eqOutMse[15:8];
            `EQPT_OFF_EQOLO: rdMux = eqOutMse[7:0];
            `EQPT_OFF_CLIPHI: rdMux = {ptOutMse[18:16], upHi_reg, loHi_reg, dcLevelReadback[8]};
            `EQPT_OFF_PTOMID: rdMux = ptOutMse[15:8];
            `EQPT_OFF_PTOLO: rdMux = ptOutMse[7:0];
            `EQPT_OFF_UPLO: rdMux = upLo_reg;
            `EQPT_OFF_LOLO: rdMux = loLo_reg;
            `EQPT_OFF_DCLO: rdMux = dcLevelReadback[7:0];
            default: rdMux = 8'h00;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            regRdata <= 8'h00;
            regAck <= 1'b0;
        end else begin
            regAck <= regRd;
            if (regRd) begin
                regRdata <= rdMux;
            end
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence s_lockedWrite;
        regWr && regAddr == `EQPT_OFF_FBCTRL && fbCtrl_reg[`EQPT_BIT_LOCK];
    endsequence

    property p_lockHolds;
        @(posedge mclk) disable iff (sys_rst) s_lockedWrite |=> $stable(coefAccessOpen);
    endproperty
    a_lockHolds: assert property (p_lockHolds) else $error("access mode changed while locked");

    property p_fb16;
        @(posedge mclk) disable iff (sys_rst) vsbLevel == 2'h3 |-> fbFilterOn == !fbCtrl_reg[7];
    endproperty
    a_fb16: assert property (p_fb16) else $error("16-level feedback enable wrong");

    property p_fbLow;
        @(posedge mclk) disable iff (sys_rst) vsbLevel < 2'h2 |-> fbFilterOn == !fbCtrl_reg[6];
    endproperty
    a_fbLow: assert property (p_fbLow) else $error("low-level feedback enable wrong");

    property p_adapt;
        @(posedge mclk) disable iff (sys_rst) fbCtrl_reg[5] && !trainingActive |-> !adaptEnable;
    endproperty
    a_adapt: assert property (p_adapt) else $error("adaptation outside training");

    property p_clipUp;
        @(posedge mclk) disable iff (sys_rst) eqErrIn > upLimit |=> eqErrOut == '0;
    endproperty
    a_clipUp: assert property (p_clipUp) else $error("error above upper clip not zeroed");

    property p_clipLo;
        @(posedge mclk) disable iff (sys_rst) eqErrIn < loLimit |=> eqErrOut == '0;
    endproperty
    a_clipLo: assert property (p_clipLo) else $error("error below lower clip not zeroed");

    property p_readAck;
        @(posedge mclk) disable iff (sys_rst) regRd && regAddr == `EQPT_OFF_DCLO
            |=> regAck && regRdata == $past(dcLevelReadback[7:0]);
    endproperty
    a_readAck: assert property (p_readAck) else $error("dc readback wrong");

    property p_writeStrobe;
        @(posedge mclk) disable iff (sys_rst) coefWriteStrobe |-> coefAccessOpen && fbCtrl_reg[1];
    endproperty
    a_writeStrobe: assert property (p_writeStrobe) else $error("write strobe outside access");

    property p_tapSide;
        @(posedge mclk) disable iff (sys_rst) tapIsFeedback == (tapIndex > 8'h3f);
    endproperty
    a_tapSide: assert property (p_tapSide) else $error("tap side decode wrong");

    sequence s_unlockedModeWrite;
        regWr && regAddr == `EQPT_OFF_FBCTRL && !fbCtrl_reg[`EQPT_BIT_LOCK];
    endsequence

    property p_modeWrite;
        @(posedge mclk) disable iff (sys_rst) s_unlockedModeWrite |=> coefAccessOpen == !$past(regWdata[0]);
    endproperty
    a_modeWrite: assert property (p_modeWrite) else $error("access mode not taken while unlocked");

    property p_blind2;
        @(posedge mclk) disable iff (sys_rst) fbCtrl_reg[4] |-> blindMode == eqpt_pkg::EQPT_BLIND_2LVL;
    endproperty
    a_blind2: assert property (p_blind2) else $error("2-level blind mode wrong");

    property p_readStrobe;
        @(posedge mclk) disable iff (sys_rst) coefReadStrobe |-> coefAccessOpen && !fbCtrl_reg[`EQPT_BIT_DIR];
    endproperty
    a_readStrobe: assert property (p_readStrobe) else $error("read strobe outside access");

    property p_slicePred;
        @(posedge mclk) disable iff (sys_rst) ptCtrl_reg[7:6] == 2'h0 |-> !slicePredOn;
    endproperty
    a_slicePred: assert property (p_slicePred) else $error("slice prediction not off");

    property p_rangeWrite;
        @(posedge mclk) disable iff (sys_rst) regWr && regAddr == `EQPT_OFF_PTCTRL
            |=> phaseRange45 == $past(regWdata[2]);
    endproperty
    a_rangeWrite: assert property (p_rangeWrite) else $error("phase range bit not taken");

    property p_coefWrite;
        @(posedge mclk) disable iff (sys_rst) regWr && regAddr == `EQPT_OFF_WRLO
            |=> coefWriteValue[7:0] == $past(regWdata);
    endproperty
    a_coefWrite: assert property (p_coefWrite) else $error("write coefficient low byte wrong");

    property p_coefHiRead;
        @(posedge mclk) disable iff (sys_rst) regRd && regAddr == `EQPT_OFF_COEFHI
            |=> regRdata[3:0] == $past(coefReadValue[11:8]);
    endproperty
    a_coefHiRead: assert property (p_coefHiRead) else $error("read coefficient high nibble wrong");

endmodule

// ### tb/eqpt_eq_model.sv
// behavioural equalizer coefficient store facing the register bank
module eqpt_eq_model (
    input wire logic mclk, // system clock
    input wire logic coefWriteStrobe, // store request
    input wire logic coefReadStrobe, // fetch request
    input wire logic [7:0] tapIndex, // selected tap
    input wire logic [11:0] coefWriteValue, // coefficient to store
    output logic [11:0] coefReadValue // fetched coefficient
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [11:0] tapMem [256] = '{default: 12'h000};
    always @(posedge mclk) begin
        if (coefWriteStrobe) tapMem[tapIndex] <= coefWriteValue;
    end
    always @(posedge mclk) begin
        if (coefReadStrobe) coefReadValue <= tapMem[tapIndex];
    end
endmodule

// ### tb/eqpt_ctrl_regs_tb.sv
// self-checking bench of the equalizer/phase-tracker register bank
`define CHK(nm, e, g) begin checksDone++; if ((g) !== (e)) begin mismatches++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module eqpt_ctrl_regs_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 0, sys_rst = 1, regWr = 0, regRd = 0, trainingActive = 0, regAck;
    logic [7:0] regAddr = 0, regWdata = 0, regRdata, tapIndex, d;
    logic [5:0] dec;
    logic [1:0] vsbLevel = 0;
    logic [11:0] coefReadValue, coefWriteValue, c;
    logic [18:0] eqInMse = 0, eqOutMse = 0, ptOutMse = 0;
    logic [8:0] dcLevelReadback = 0;
    logic signed [9:0] eqErrIn = 0, eqErrOut;
    logic [9:0] dataAdaptRange;
    logic [15:0] seed = 16'h0007, r;
    logic [63:0] t;
    logic fbFilterOn, adaptEnable, coefAccessOpen, coefWriteStrobe, coefReadStrobe, tapIsFeedback;
    logic slicePredOn, phaseRange45, loopGainValueSel, loopGainThreshSel;
    eqpt_pkg::eqpt_blind_e blindMode;
    eqpt_pkg::eqpt_gain_e loopGainMode;
    int mismatches = 0, checksDone = 0;
    logic [7:0] ra [11], rv [11], taps [4];
    logic signed [9:0] errs [5] = '{10'sd48, 10'sd49, -10'sd48, -10'sd49, 10'sd0};

    eqpt_ctrl_regs dut (.mclk(mclk), .sys_rst(sys_rst), .regWr(regWr), .regRd(regRd), .regAddr(regAddr),
        .regWdata(regWdata), .regRdata(regRdata), .regAck(regAck), .vsbLevel(vsbLevel),
        .trainingActive(trainingActive), .coefReadValue(coefReadValue), .eqInMse(eqInMse),
        .eqOutMse(eqOutMse), .ptOutMse(ptOutMse), .dcLevelReadback(dcLevelReadback), .eqErrIn(eqErrIn),
        .eqErrOut(eqErrOut), .fbFilterOn(fbFilterOn), .adaptEnable(adaptEnable), .blindMode(blindMode),
        .coefAccessOpen(coefAccessOpen), .coefWriteStrobe(coefWriteStrobe), .coefReadStrobe(coefReadStrobe),
        .tapIndex(tapIndex), .tapIsFeedback(tapIsFeedback), .coefWriteValue(coefWriteValue),
        .dataAdaptRange(dataAdaptRange), .slicePredOn(slicePredOn), .loopGainMode(loopGainMode),
        .phaseRange45(phaseRange45), .loopGainValueSel(loopGainValueSel), .loopGainThreshSel(loopGainThreshSel));
    eqpt_eq_model model (.mclk(mclk), .coefWriteStrobe(coefWriteStrobe), .coefReadStrobe(coefReadStrobe),
        .tapIndex(tapIndex), .coefWriteValue(coefWriteValue), .coefReadValue(coefReadValue));

    always #5 mclk = ~mclk;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [15:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed;
    endfunction
    function automatic logic fb_exp(logic [1:0] lvl, logic b7, logic b6);
        return (lvl == 2'd3) ? !b7 : (lvl == 2'd2) ? 1'b1 : !b6;
    endfunction
    function automatic eqpt_pkg::eqpt_blind_e blind_exp(logic [1:0] b);
        return (b == 2'd0) ? eqpt_pkg::EQPT_BLIND_OFF : (b == 2'd1) ? eqpt_pkg::EQPT_BLIND_4LVL :
            eqpt_pkg::EQPT_BLIND_2LVL;
    endfunction
    function automatic eqpt_pkg::eqpt_gain_e gain_exp(logic [2:0] g);
        return g[2] ? eqpt_pkg::EQPT_GAIN_UNUSED : eqpt_pkg::eqpt_gain_e'(g);
    endfunction
    function automatic logic signed [9:0] clip_exp(logic signed [9:0] e);
        return (e > 10'sd48 || e < -10'sd48) ? 10'sd0 : e;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] dd);
        @(posedge mclk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= dd;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRd <= 1'b0;
        #1;
        `CHK("regAck", 1'b1, regAck)
        `CHK(nm, e, regRdata)
    endtask
    task automatic settle();
        @(posedge mclk);
        #1;
    endtask
    task testDone();
        $display("checks %0d mismatches %0d", checksDone, mismatches);
        if (mismatches == 0 && checksDone > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        ra = '{8'h23, 8'h24, 8'h25, 8'h27, 8'h2a, 8'h32, 8'h33, 8'h2f, 8'h29, 8'h35, 8'h22};
        rv = '{8'ha7, 8'hc3, 8'h00, 8'h00, 8'h90, 8'h00, 8'h00, 8'h0e, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 11; i++) rchk("reset value", ra[i], rv[i]);
        dec = {slicePredOn, phaseRange45, loopGainValueSel, loopGainThreshSel, coefAccessOpen, tapIsFeedback};
        `CHK("decodes", 6'b101100, dec)
        `CHK("blindMode", eqpt_pkg::EQPT_BLIND_OFF, blindMode)
        `CHK("loopGainMode", eqpt_pkg::EQPT_GAIN_AUTO, loopGainMode)
        `CHK("dataAdaptRange", 10'h090, dataAdaptRange)
        $display("test reset done");
        for (int i = 0; i < 32; i++) begin
            wr(8'h23, {i[2], i[3], i[4], 5'b00111});
            vsbLevel <= i[1:0];
            trainingActive <= i[0] ^ i[3];
            settle();
            `CHK("fbFilterOn", fb_exp(i[1:0], i[2], i[3]), fbFilterOn)
            `CHK("adaptEnable", (i[0] ^ i[3]) | !i[4], adaptEnable)
        end
        for (int b = 0; b < 4; b++) begin
            wr(8'h23, {3'b101, b[1:0], 3'b111});
            settle();
            `CHK("blindMode", blind_exp(b[1:0]), blindMode)
        end
        for (int i = 0; i < 12; i++) begin
            r = rnd();
            d = {r[7], r[7], (i < 8) ? i[2:0] : r[5:3], r[2:0]};
            wr(8'h24, d);
            settle();
            `CHK("loopGainMode", gain_exp(d[5:3]), loopGainMode)
            dec = {2'b00, slicePredOn, phaseRange45, loopGainValueSel, loopGainThreshSel};
            `CHK("tracker bits", {2'b00, d[7], d[2:0]}, dec)
            rchk("tracker reg", 8'h24, d);
        end
        $display("test decodes done");
        wr(8'h23, 8'h26);
        rchk("locked mode", 8'h23, 8'h27);
        wr(8'h23, 8'h23);
        wr(8'h23, 8'h22);
        rchk("unlocked mode", 8'h23, 8'h22);
        `CHK("coefAccessOpen", 1'b1, coefAccessOpen)
        taps = '{8'h3f, 8'h40, 8'hff, 8'h00};
        r = rnd();
        taps[3] = r[7:0];
        foreach (taps[k]) begin
            r = rnd();
            c = r[11:0];
            wr(8'h23, 8'h22);
            wr(8'h25, taps[k]);
            #1;
            `CHK("coefReadStrobe idle", 1'b0, coefReadStrobe)
            `CHK("tapIndex", taps[k], tapIndex)
            wr(8'h26, {c[11:8], 4'h0});
            wr(8'h27, c[7:0]);
            #1;
            `CHK("coefWriteStrobe", 1'b1, coefWriteStrobe)
            `CHK("coefWriteValue", c, coefWriteValue)
            `CHK("tapIsFeedback", taps[k] > 8'd63, tapIsFeedback)
            wr(8'h23, 8'h20);
            wr(8'h25, taps[k]);
            #1;
            `CHK("coefReadStrobe", 1'b1, coefReadStrobe)
            rchk("coef high", 8'h26, {c[11:8], c[11:8]});
            rchk("coef low", 8'h28, c[7:0]);
        end
        wr(8'h23, 8'h27);
        wr(8'h27, 8'h5a);
        #1;
        `CHK("coefWriteStrobe closed", 1'b0, coefWriteStrobe)
        `CHK("coefAccessOpen", 1'b0, coefAccessOpen)
        $display("test coefficients done");
        for (int i = 0; i < 4; i++) begin
            r = rnd();
            wr(8'h29, r[7:0]);
            wr(8'h2a, r[15:8]);
            t = {rnd(), rnd(), rnd(), rnd()};
            eqInMse <= t[18:0];
            eqOutMse <= t[37:19];
            ptOutMse <= t[56:38];
            dcLevelReadback <= {t[63:57], t[5:4]};
            settle();
            `CHK("dataAdaptRange", {r[7:6], r[15:8]}, dataAdaptRange)
            ra = '{8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h30, 8'h31, 8'h34, 8'h35, 8'h22, 8'h29, 8'h2f};
            rv = '{eqInMse[15:8], eqInMse[7:0], eqOutMse[15:8], eqOutMse[7:0], ptOutMse[15:8], ptOutMse[7:0],
                dcLevelReadback[7:0], 8'h00, 8'h00, {r[7:6], eqInMse[18:16], eqOutMse[17:16], 1'b0},
                {ptOutMse[18:16], 4'b0111, dcLevelReadback[8]}};
            for (int j = 0; j < 11; j++) rchk("monitor", ra[j], rv[j]);
        end
        $display("test monitors done");
        wr(8'h2f, 8'hff);
        wr(8'h2f, 8'h06);
        wr(8'h32, 8'h30);
        wr(8'h33, 8'hd0);
        rchk("clip high bits", 8'h2f, {ptOutMse[18:16], 4'b0011, dcLevelReadback[8]});
        for (int i = 0; i < 25; i++) begin
            r = rnd();
            @(posedge mclk);
            eqErrIn <= (i < 5) ? errs[i] : r[9:0];
            settle();
            `CHK("eqErrOut", clip_exp(eqErrIn), eqErrOut)
        end
        $display("test clipping done");
        @(posedge mclk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        rchk("second reset", 8'h23, 8'ha7);
        rchk("second reset clip", 8'h2f, {ptOutMse[18:16], 4'b0111, dcLevelReadback[8]});
        $display("test second reset done");
        testDone();
    end

    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        testDone();
    end
endmodule
